// file: design/dsf_pkg.sv
/*
 * Package for the slave diagnostic frame builder: frame offsets, bit positions,
 * interrupt codes, lengths, register map and reset values.
 * Assumes nothing of its surroundings.
 */
package dsf_pkg;

	// =====================================================
	// Station status bit positions
	localparam int unsigned ST1_UNREACH = 0;
	localparam int unsigned ST1_NOT_READY = 1;
	localparam int unsigned ST1_CFG_FAULT = 2;
	localparam int unsigned ST1_RUN_STOP = 3;
	localparam int unsigned ST1_UNSUPP = 4;
	localparam int unsigned ST1_TYPE_FAULT = 6;
	localparam int unsigned ST1_OTHER_MST = 7;
	localparam int unsigned ST2_NEED_PRM = 0;
	localparam int unsigned ST2_STATIC = 1;
	localparam int unsigned ST2_PRESENT = 2;
	localparam int unsigned ST2_WDOG = 3;
	localparam int unsigned ST2_FREEZE = 4;
	localparam int unsigned ST2_SYNC = 5;
	localparam int unsigned ST2_DISABLED = 7;
	localparam int unsigned ST3_OVERFLOW = 7;

	// =====================================================
	// Frame layout
	localparam logic [7:0] MST_NONE = 8'hff;
	localparam int unsigned HDR_LEN = 6;
	localparam int unsigned MOD_MAX = 13;
	localparam int unsigned IRQ_MAX = 20;
	localparam int unsigned IRQ_INFO_LEN = 4;
	localparam int unsigned DIAG_DATA_LEN = 16;
	localparam logic [7:0] CODE_DIAG = 8'h01;
	localparam logic [7:0] CODE_PROC = 8'h02;
	localparam logic [7:0] IRQ_HDR_LEN = 8'h04;
	localparam int unsigned FRAME_MAX = HDR_LEN + MOD_MAX + IRQ_MAX;

	// Arbitrary neutral type code, not a real maker's value
	localparam logic [15:0] TYPE_CODE_DEF = 16'h1234;

	// =====================================================
	// Register map (byte addresses, word aligned)
	localparam logic [5:0] A_CTRL = 6'h00;
	localparam logic [5:0] A_MST = 6'h04;
	localparam logic [5:0] A_MOD = 6'h08;
	localparam logic [5:0] A_IRQ = 6'h0c;
	localparam logic [5:0] A_INFO = 6'h10;
	localparam logic [5:0] A_STAT = 6'h14;
	localparam logic [5:0] A_FRAME = 6'h18;

	// CTRL bit positions
	localparam int unsigned C_STATIC = 8;
	localparam int unsigned C_WDOG = 9;
	localparam int unsigned C_DISABLE = 10;
	localparam int unsigned C_OVF_CLR = 11;
	localparam int unsigned C_RDY = 12;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] MOD_LEN_RST = 8'h03;

	typedef enum logic [1:0] {IRQ_NONE = 2'b00, IRQ_PROC = 2'b01, IRQ_DIAG = 2'b11} dsf_irq_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_SEND = 2'b01, S_LAST = 2'b11} dsf_state_t;

endpackage

// file: design/dsf_tx_if.sv
/*
 * Byte stream between the frame builder and its serialiser.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface dsf_tx_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	logic last;
	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface

// file: design/dsf_frame_rom.sv
/*
 * Byte selector: returns frame byte at index from the assembled fields.
 * Assumes fields are stable while the frame is sent.
 */
`timescale 1ns/1ps
module dsf_frame_rom (
	input wire logic [7:0] st1,
	input wire logic [7:0] st2,
	input wire logic [7:0] st3,
	input wire logic [7:0] mst,
	input wire logic [15:0] type_code,
	input wire logic [8*dsf_pkg::MOD_MAX-1:0] mod_bytes,
	input wire logic [7:0] mod_len,
	input wire dsf_pkg::dsf_irq_t irq_kind,
	input wire logic [31:0] irq_info,
	input wire logic [5:0] idx,
	output logic [7:0] byte_o
);
	logic [5:0] irq_base;
	logic [5:0] rel;

	always_comb begin
		irq_base = 6'(dsf_pkg::HDR_LEN) + mod_len[5:0];
		rel = idx - irq_base;
		byte_o = 8'h00;
		// Ascending frame order
		if (idx == 6'h00) begin
			byte_o = st1;
		end else if (idx == 6'h01) begin
			byte_o = st2;
		end else if (idx == 6'h02) begin
			byte_o = st3;
		end else if (idx == 6'h03) begin
			byte_o = mst;
		end else if (idx == 6'h04) begin
			byte_o = type_code[7:0];
		end else if (idx == 6'h05) begin
			byte_o = type_code[15:8];
		end else if (idx < irq_base) begin
			byte_o = mod_bytes[8*(idx - 6'(dsf_pkg::HDR_LEN)) +: 8];
		end else if (rel == 6'h00) begin
			byte_o = dsf_pkg::IRQ_HDR_LEN;
		end else if (rel == 6'h01) begin
			byte_o = (irq_kind == dsf_pkg::IRQ_PROC) ? dsf_pkg::CODE_PROC : dsf_pkg::CODE_DIAG;
		end else if (rel >= 6'h04 && rel < 6'h08) begin
			// Four info bytes; diag tail stays zero
			byte_o = irq_info[8*(rel - 6'h04) +: 8];
		end
	end
endmodule

// file: design/dsf_frame.sv
/*
 * Slave diagnostic frame builder with Avalon-MM register slave.
 * Assumes synchronous status inputs and a downstream byte serialiser.
 */
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Unreachable slave sets status1 bit0
// - Not ready for exchange sets bit1
// - Configuration mismatch sets bit2
// - Bit3 one on run-stop, zero stop-run
// - Unsupported function request sets bit4
// - Slave type mismatch sets bit6
// - Non-configuring accessor sets bit7
// - Fixed-zero bits stay zero
// - Parameter reload needed sets status2 bit0
// - Static diagnostic holds operation until cleared
// - Present bit always one
// - Watchdog enabled sets bit3
// - Freeze sets bit4, sync sets bit5
// - Deactivated slave sets bit7
// - Message overflow sets status3 bit7
// - Master address byte, all ones if none
// - Fixed type code, low byte first
// - Module diagnostics flag written areas
// - Module status at most 13 bytes
// - Interrupt status at most 20 bytes
// - Process interrupt: code 02, four info bytes
// - Diag interrupt: code 01, sixteen bytes
module dsf_frame #(
	parameter logic [15:0] TYPE_CODE = dsf_pkg::TYPE_CODE_DEF,
	parameter int unsigned MSG_DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic link_unreach,
	input wire logic cfg_mismatch,
	input wire logic unsupp_req,
	input wire logic type_mismatch,
	input wire logic other_master,
	input wire logic need_prm,
	input wire logic freeze_cmd,
	input wire logic sync_cmd,
	input wire logic plc_run,
	input wire logic msg_push,
	input wire logic msg_pop,
	input wire logic frame_req,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic op_hold
);
	// =====================================================
	// State
	typedef struct packed {
		logic [31:0] ctrl;
		logic [7:0] mst;
		logic [8*dsf_pkg::MOD_MAX-1:0] mods;
		logic [7:0] mod_len;
		dsf_pkg::dsf_irq_t irq_kind;
		logic [31:0] info;
		logic run_stop;
		logic plc_run_d;
		logic freeze;
		logic sync;
		logic overflow;
		logic [3:0] msg_cnt;
		dsf_pkg::dsf_state_t st;
		logic [5:0] idx;
		logic [5:0] flen;
		logic [31:0] rdata;
		logic ack;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_last;
		logic op_hold;
		logic wreq;
	} dsf_regs_t;

	dsf_regs_t q_r;
	dsf_regs_t q_nxt;

	dsf_tx_if tx_bus ();

	logic [7:0] st1;
	logic [7:0] st2;
	logic [7:0] st3;
	logic [7:0] rom_byte;
	logic [5:0] mod_len_c;
	logic [5:0] irq_len_c;
	logic [31:0] wmask;

	// =====================================================
	// Station status assembly
	always_comb begin
		st1 = 8'h00; // Unlisted bits stay zero
		st1[dsf_pkg::ST1_UNREACH] = link_unreach;
		st1[dsf_pkg::ST1_NOT_READY] = ~q_r.ctrl[dsf_pkg::C_RDY];
		st1[dsf_pkg::ST1_CFG_FAULT] = cfg_mismatch;
		st1[dsf_pkg::ST1_RUN_STOP] = q_r.run_stop;
		st1[dsf_pkg::ST1_UNSUPP] = unsupp_req;
		st1[dsf_pkg::ST1_TYPE_FAULT] = type_mismatch;
		st1[dsf_pkg::ST1_OTHER_MST] = other_master;
		st2 = 8'h00;
		st2[dsf_pkg::ST2_NEED_PRM] = need_prm;
		st2[dsf_pkg::ST2_STATIC] = q_r.ctrl[dsf_pkg::C_STATIC];
		st2[dsf_pkg::ST2_PRESENT] = 1'b1;
		st2[dsf_pkg::ST2_WDOG] = q_r.ctrl[dsf_pkg::C_WDOG];
		st2[dsf_pkg::ST2_FREEZE] = q_r.freeze;
		st2[dsf_pkg::ST2_SYNC] = q_r.sync;
		st2[dsf_pkg::ST2_DISABLED] = q_r.ctrl[dsf_pkg::C_DISABLE];
		st3 = 8'h00;
		st3[dsf_pkg::ST3_OVERFLOW] = q_r.overflow;
	end

	// Length of interrupt part: none, 4+4 for process, 4+16 for diagnostic
	always_comb begin
		mod_len_c = (q_r.mod_len > 8'(dsf_pkg::MOD_MAX)) ? 6'(dsf_pkg::MOD_MAX) :
			q_r.mod_len[5:0];
		unique case (q_r.irq_kind)
			dsf_pkg::IRQ_PROC: irq_len_c = 6'(4 + dsf_pkg::IRQ_INFO_LEN);
			dsf_pkg::IRQ_DIAG: irq_len_c = 6'(4 + dsf_pkg::DIAG_DATA_LEN);
			default: irq_len_c = 6'h00;
		endcase
	end

	dsf_frame_rom u_rom (
		.st1(st1),
		.st2(st2),
		.st3(st3),
		.mst(q_r.mst),
		.type_code(TYPE_CODE),
		.mod_bytes(q_r.mods),
		.mod_len({2'b00, mod_len_c}),
		.irq_kind(q_r.irq_kind),
		.irq_info(q_r.info),
		.idx(q_r.idx),
		.byte_o(rom_byte)
	);

	assign tx_bus.valid = q_r.tx_valid;
	assign tx_bus.data = q_r.tx_data;
	assign tx_bus.last = q_r.tx_last;
	assign tx_bus.ready = tx_ready;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[8*i +: 8] = {8{avs_byteenable[i]}};
		end
	end

	// =====================================================
	// Next state
	always_comb begin
		logic push_ok;
		logic [31:0] wv;
		push_ok = 1'b0;
		wv = 32'h0;
		q_nxt = q_r;
		q_nxt.plc_run_d = plc_run;
		q_nxt.ack = 1'b0;
		// Run to stop drives bit one, stop to run zero
		if (q_r.plc_run_d && !plc_run) begin
			q_nxt.run_stop = 1'b1;
			q_nxt.irq_kind = dsf_pkg::IRQ_DIAG;
		end else if (!q_r.plc_run_d && plc_run) begin
			q_nxt.run_stop = 1'b0;
			q_nxt.irq_kind = dsf_pkg::IRQ_DIAG;
		end
		// Commands seen; cleared by a new parameter download
		if (need_prm) begin
			q_nxt.freeze = 1'b0;
			q_nxt.sync = 1'b0;
		end
		if (freeze_cmd) begin
			q_nxt.freeze = 1'b1;
		end
		if (sync_cmd) begin
			q_nxt.sync = 1'b1;
		end
		// Pending message count; overflow sticks until cleared
		if (msg_push && !msg_pop) begin
			if (q_r.msg_cnt == 4'(MSG_DEPTH)) begin
				push_ok = 1'b0;
			end else begin
				push_ok = 1'b1;
				q_nxt.msg_cnt = q_r.msg_cnt + 4'h1;
			end
		end else if (msg_pop && !msg_push && q_r.msg_cnt != 4'h0) begin
			q_nxt.msg_cnt = q_r.msg_cnt - 4'h1;
		end
		// Register slave, one wait cycle per access
		if ((avs_read || avs_write) && !q_r.ack) begin
			q_nxt.ack = 1'b1;
			q_nxt.rdata = 32'h0;
			if (avs_write) begin
				unique case (avs_address)
					dsf_pkg::A_CTRL: begin
						wv = (q_r.ctrl & ~wmask) | (avs_writedata & wmask);
						q_nxt.ctrl = wv & ~(32'h1 << dsf_pkg::C_OVF_CLR);
						if (wv[dsf_pkg::C_OVF_CLR]) begin
							q_nxt.overflow = 1'b0;
						end
					end
					dsf_pkg::A_MST: q_nxt.mst = avs_writedata[7:0];
					dsf_pkg::A_MOD: begin
						q_nxt.mod_len = avs_writedata[15:8];
						// Flag area that received an entry
						if (avs_writedata[6:0] < 7'(8 * (dsf_pkg::MOD_MAX - 1))) begin
							q_nxt.mods[8 + avs_writedata[6:0]] = 1'b1;
						end
					end
					dsf_pkg::A_IRQ: begin
						if (avs_writedata[1:0] == 2'b01) begin
							q_nxt.irq_kind = dsf_pkg::IRQ_PROC;
						end else if (avs_writedata[1:0] == 2'b00) begin
							q_nxt.irq_kind = dsf_pkg::IRQ_NONE;
							q_nxt.mods = '0;
						end
					end
					dsf_pkg::A_INFO: q_nxt.info = avs_writedata;
					default: q_nxt.rdata = 32'h0;
				endcase
			end else begin
				unique case (avs_address)
					dsf_pkg::A_CTRL: q_nxt.rdata = q_r.ctrl;
					dsf_pkg::A_MST: q_nxt.rdata = {24'h0, q_r.mst};
					dsf_pkg::A_MOD: q_nxt.rdata = {16'h0, q_r.mod_len, 8'h00};
					dsf_pkg::A_IRQ: q_nxt.rdata = {30'h0, q_r.irq_kind};
					dsf_pkg::A_INFO: q_nxt.rdata = q_r.info;
					dsf_pkg::A_STAT: q_nxt.rdata = {8'h00, st3, st2, st1};
					dsf_pkg::A_FRAME: q_nxt.rdata = {TYPE_CODE, 4'h0, q_r.msg_cnt, q_r.mst};
					default: q_nxt.rdata = 32'h0;
				endcase
			end
		end
		// Overflow: set wins over clear
		if (msg_push && !msg_pop && !push_ok) begin
			q_nxt.overflow = 1'b1;
		end
		// Frame sender, strictly ascending index
		unique case (q_r.st)
			dsf_pkg::S_IDLE: begin
				if (frame_req) begin
					q_nxt.flen = 6'(dsf_pkg::HDR_LEN) + mod_len_c + irq_len_c;
					q_nxt.idx = 6'h00;
					q_nxt.st = dsf_pkg::S_SEND;
				end
			end
			dsf_pkg::S_SEND: begin
				if (!tx_bus.valid || tx_bus.ready) begin
					q_nxt.tx_valid = 1'b1;
					q_nxt.tx_data = rom_byte;
					q_nxt.tx_last = (q_r.idx == q_r.flen - 6'h01);
					q_nxt.idx = q_r.idx + 6'h01;
					if (q_r.idx == q_r.flen - 6'h01) begin
						q_nxt.st = dsf_pkg::S_LAST;
					end
				end
			end
			dsf_pkg::S_LAST: begin
				if (tx_bus.ready) begin
					q_nxt.tx_valid = 1'b0;
					q_nxt.tx_last = 1'b0;
					q_nxt.st = dsf_pkg::S_IDLE;
				end
			end
			default: q_nxt.st = dsf_pkg::S_IDLE;
		endcase
		// Hold while not ready or static diagnostic stands
		q_nxt.op_hold = q_nxt.ctrl[dsf_pkg::C_STATIC] | ~q_nxt.ctrl[dsf_pkg::C_RDY];
		// Waitrequest low only in the answer cycle
		q_nxt.wreq = ~q_nxt.ack;
	end

	// =====================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			q_r <= '0;
			q_r.ctrl <= dsf_pkg::CTRL_RST;
			q_r.mst <= dsf_pkg::MST_NONE;
			q_r.mod_len <= dsf_pkg::MOD_LEN_RST;
			q_r.st <= dsf_pkg::S_IDLE;
			q_r.irq_kind <= dsf_pkg::IRQ_NONE;
			q_r.op_hold <= 1'b1;
			q_r.wreq <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign avs_readdata = q_r.rdata;
	assign avs_waitrequest = q_r.wreq;
	assign tx_valid = q_r.tx_valid;
	assign tx_data = q_r.tx_data;
	assign tx_last = q_r.tx_last;
	assign op_hold = q_r.op_hold;

	// =====================================================
	// Checks
	property p_master_none;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(rstn) |-> q_r.mst == dsf_pkg::MST_NONE;
	endproperty
	a_master_none: assert property (p_master_none) else $error("master byte not ff");

	property p_present;
		@(posedge clk_sys) disable iff (!rstn)
		st2[dsf_pkg::ST2_PRESENT] && !st2[6] && !st1[5] && st3[6:0] == 7'h0;
	endproperty
	a_present: assert property (p_present) else $error("fixed status bits wrong");

	property p_run_stop;
		@(posedge clk_sys) disable iff (!rstn)
		(q_r.plc_run_d && !plc_run) |=> st1[dsf_pkg::ST1_RUN_STOP];
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("run-stop not shown");

	property p_stop_run;
		@(posedge clk_sys) disable iff (!rstn)
		(!q_r.plc_run_d && plc_run) |=> !st1[dsf_pkg::ST1_RUN_STOP];
	endproperty
	a_stop_run: assert property (p_stop_run) else $error("stop-run not shown");

	property p_freeze;
		@(posedge clk_sys) disable iff (!rstn)
		freeze_cmd |=> st2[dsf_pkg::ST2_FREEZE];
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze bit not set");

	property p_overflow;
		@(posedge clk_sys) disable iff (!rstn)
		(msg_push && !msg_pop && q_r.msg_cnt == 4'(MSG_DEPTH)) |=> st3[dsf_pkg::ST3_OVERFLOW];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged");

	property p_hold;
		@(posedge clk_sys) disable iff (!rstn)
		q_r.ctrl[dsf_pkg::C_STATIC] |-> op_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("operation not held");

	property p_first_byte;
		@(posedge clk_sys) disable iff (!rstn)
		(q_r.st == dsf_pkg::S_IDLE && frame_req) |-> ##[1:2] (tx_valid && tx_data == $past(st1));
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("frame not begun with status1");

	property p_irq_len;
		@(posedge clk_sys) disable iff (!rstn)
		q_r.st != dsf_pkg::S_IDLE |-> q_r.flen <= 6'(dsf_pkg::FRAME_MAX);
	endproperty
	a_irq_len: assert property (p_irq_len) else $error("frame too long");

endmodule

// file: dv/dsf_master_model.sv
/*
 * Stand-in for the bus master that reads slave diagnostic frames.
 * Assumes the valid/ready byte stream of the frame builder, one clock.
 */
`timescale 1ns/1ps
module dsf_master_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic slow,
	input wire logic clr,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [7:0] mem [0:63];
	int cnt;
	int last_pos;
	logic done;
	logic tick = 1'b0;

	// Slow reader stalls every other cycle
	assign tx_ready = !slow || tick;

	// Keep the first 64 bytes read, in arrival order
	always @(posedge clk_sys) begin
		tick <= !tick;
		if (!rstn || clr) begin
			cnt <= 0;
			done <= 1'b0;
			last_pos <= -1;
		end else if (tx_valid && tx_ready && cnt < 64) begin
			mem[cnt] <= tx_data;
			cnt <= cnt + 1;
			if (tx_last) begin
				done <= 1'b1;
				last_pos <= cnt;
			end
		end
	end
endmodule

// file: dv/tb_top.sv
/*
 * Self-checking bench for the diagnostic frame builder.
 * Assumes the register map and byte order of the frame builder.
 */
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [5:0] lv = 6'h00;
	logic freeze_cmd = 1'b0;
	logic sync_cmd = 1'b0;
	logic plc_run = 1'b0;
	logic msg_push = 1'b0;
	logic msg_pop = 1'b0;
	logic frame_req = 1'b0;
	logic slow = 1'b0;
	logic clr = 1'b0;
	logic tx_ready, tx_valid, tx_last, op_hold;
	logic [7:0] tx_data;
	logic [31:0] rd;
	int fails = 0;
	int n_tests = 0;
	localparam int unsigned MSG_DEPTH = 4;

	dsf_frame #(.MSG_DEPTH(MSG_DEPTH)) uut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link_unreach(lv[0]), .cfg_mismatch(lv[1]),
		.unsupp_req(lv[2]), .type_mismatch(lv[3]), .other_master(lv[4]), .need_prm(lv[5]),
		.freeze_cmd(freeze_cmd), .sync_cmd(sync_cmd), .plc_run(plc_run),
		.msg_push(msg_push), .msg_pop(msg_pop), .frame_req(frame_req),
		.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.op_hold(op_hold));

	dsf_master_model mdl (.clk_sys(clk_sys), .rstn(rstn), .slow(slow), .clr(clr),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	// =====================================================
	// Shared tasks
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task tmo(input string nm);
		fails++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		final_report();
	endtask

	task av(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !w;
		avs_write <= w;
		n = 0;
		@(posedge clk_sys);
		// Sampled before this edge's updates; data taken at the same edge
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20)
				tmo("waitrequest");
			@(posedge clk_sys);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task stat(input string nm, input logic [31:0] e);
		repeat (2) @(posedge clk_sys);
		av(1'b0, 6'h14, 32'h0, 4'hf);
		chk(nm, e, rd);
	endtask

	task pulse_push(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			msg_push <= 1'b1;
			@(posedge clk_sys);
			msg_push <= 1'b0;
		end
	endtask

	task get_frame(input logic s);
		int n;
		@(posedge clk_sys);
		slow <= s;
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
		frame_req <= 1'b1;
		@(posedge clk_sys);
		frame_req <= 1'b0;
		n = 0;
		while (mdl.done !== 1'b1) begin
			@(posedge clk_sys);
			n++;
			if (n > 500)
				tmo("frame");
		end
	endtask

	// Header with ready set, master 05; module area capped at 13 bytes
	task chk_frame(input logic [7:0] code, input int len);
		logic [7:0] h [0:5];
		int b;
		h = '{8'h00, 8'h04, 8'h00, 8'h05, 8'h34, 8'h12};
		b = 6 + dsf_pkg::MOD_MAX;
		for (int i = 0; i < 6; i++)
			chk("header byte", {24'h0, h[i]}, {24'h0, mdl.mem[i]});
		chk("irq len", 32'h04, {24'h0, mdl.mem[b]});
		chk("irq code", {24'h0, code}, {24'h0, mdl.mem[b+1]});
		chk("irq pad", 32'h0, {16'h0, mdl.mem[b+2], mdl.mem[b+3]});
		if (code == dsf_pkg::CODE_PROC)
			chk("proc info", 32'h11223344,
				{mdl.mem[b+4], mdl.mem[b+5], mdl.mem[b+6], mdl.mem[b+7]});
		else
			for (int i = 8; i < 20; i++)
				chk("diag zero", 32'h0, {24'h0, mdl.mem[b+i]});
		chk("frame len", len, mdl.cnt);
		chk("last pos", len - 1, mdl.last_pos);
	endtask

	// =====================================================
	// Scenarios
	task t_reset;
		stat("reset status", 32'h0000_0402);
		av(1'b0, 6'h18, 32'h0, 4'hf);
		chk("no master", 32'hff, {24'h0, rd[7:0]});
		chk("type code", {16'h0, dsf_pkg::TYPE_CODE_DEF}, {16'h0, rd[31:16]});
		chk("hold in reset", 32'h1, {31'h0, op_hold});
		av(1'b1, 6'h3c, 32'hffff_ffff, 4'hf);
		av(1'b0, 6'h3c, 32'h0, 4'hf);
		chk("unmapped", 32'h0, rd);
	endtask

	task t_ctrl;
		av(1'b1, 6'h00, 32'h0000_1700, 4'hf);
		stat("ctrl bits", 32'h0000_8e00);
		chk("static hold", 32'h1, {31'h0, op_hold});
		av(1'b1, 6'h00, 32'h0000_1000, 4'hf);
		stat("ctrl clear", 32'h0000_0400);
		chk("hold released", 32'h0, {31'h0, op_hold});
		av(1'b1, 6'h00, 32'h0000_0100, 4'h1);
		stat("byte enable", 32'h0000_0400);
		chk("hold masked", 32'h0, {31'h0, op_hold});
	endtask

	task t_levels;
		int pos [0:5];
		pos = '{0, 2, 4, 6, 7, 8};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			lv <= 6'(1 << i);
			stat("level bit", 32'h0400 | (32'h1 << pos[i]));
			@(posedge clk_sys);
			lv <= 6'h00;
		end
	endtask

	task t_sticky;
		@(posedge clk_sys);
		freeze_cmd <= 1'b1;
		@(posedge clk_sys);
		freeze_cmd <= 1'b0;
		sync_cmd <= 1'b1;
		@(posedge clk_sys);
		sync_cmd <= 1'b0;
		stat("freeze sync", 32'h0000_3400);
		lv <= 6'h20;
		@(posedge clk_sys);
		lv <= 6'h00;
		stat("sticky cleared", 32'h0000_0400);
	endtask

	task t_ovf;
		pulse_push(MSG_DEPTH);
		stat("store full", 32'h0000_0400);
		av(1'b0, 6'h18, 32'h0, 4'hf);
		chk("pending count", MSG_DEPTH, {28'h0, rd[11:8]});
		pulse_push(1);
		stat("overflow", 32'h0080_0400);
		av(1'b1, 6'h00, 32'h0000_1800, 4'hf);
		stat("overflow clear", 32'h0000_0400);
		repeat (MSG_DEPTH) begin
			@(posedge clk_sys);
			msg_pop <= 1'b1;
			@(posedge clk_sys);
			msg_pop <= 1'b0;
		end
		av(1'b0, 6'h18, 32'h0, 4'hf);
		chk("pending empty", 32'h0, {28'h0, rd[11:8]});
	endtask

	task t_frames;
		av(1'b1, 6'h04, 32'h05, 4'hf);
		av(1'b1, 6'h08, 32'h0000_1400, 4'hf);
		av(1'b1, 6'h10, 32'h4433_2211, 4'hf);
		av(1'b1, 6'h0c, 32'h1, 4'hf);
		av(1'b0, 6'h04, 32'h0, 4'hf);
		chk("master read", 32'h05, rd);
		av(1'b0, 6'h08, 32'h0, 4'hf);
		chk("module len read", 32'h0000_1400, rd);
		av(1'b0, 6'h0c, 32'h0, 4'hf);
		chk("irq kind read", {30'h0, dsf_pkg::IRQ_PROC}, rd);
		av(1'b0, 6'h10, 32'h0, 4'hf);
		chk("info read", 32'h4433_2211, rd);
		av(1'b0, 6'h00, 32'h0, 4'hf);
		chk("ctrl read", 32'h0000_1000, rd);
		get_frame(1'b1);
		chk_frame(dsf_pkg::CODE_PROC, 27);
		chk("module flag", 32'h01, {24'h0, mdl.mem[7]});
		chk("module idle", 32'h00, {24'h0, mdl.mem[6]});
		av(1'b1, 6'h0c, 32'h0, 4'hf);
		@(posedge clk_sys);
		plc_run <= 1'b1;
		repeat (3) @(posedge clk_sys);
		get_frame(1'b0);
		chk_frame(dsf_pkg::CODE_DIAG, 39);
		chk("module cleared", 32'h00, {24'h0, mdl.mem[7]});
		plc_run <= 1'b0;
		stat("run to stop", 32'h0000_0408);
		plc_run <= 1'b1;
		stat("stop to run", 32'h0000_0400);
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_ctrl();
		t_levels();
		t_sticky();
		t_ovf();
		t_frames();
		final_report();
	end
endmodule
